// >>> core/timer_pkg.sv
// Shared constants for the timer time base, compare channels and fault gate.
// Assumes a single 20 MHz system clock and an 8-bit word-aligned register port.
package timer_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG = 8'h04;
  localparam logic [7:0] OFS_CHCFG = 8'h08;
  localparam logic [7:0] OFS_CHEN = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_COUNTER = 8'h24;
  localparam logic [7:0] OFS_DIVIDER = 8'h28;
  localparam logic [7:0] OFS_RELOAD = 8'h2C;
  localparam logic [7:0] OFS_SKIP = 8'h30;
  localparam logic [7:0] OFS_CCR [4] = '{8'h34, 8'h38, 8'h3C, 8'h40};
  localparam logic [7:0] OFS_FAULT = 8'h44;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_RUN = 0;
  localparam int BIT_RELOAD_PRE = 1;
  localparam int BIT_CENTER = 2;
  localparam int BIT_SOFT_UPD = 0;
  localparam int BIT_GATE = 15;
  localparam int BIT_ARM = 14;
  localparam int BIT_POL = 13;
  localparam int BIT_FEN = 12;
  localparam int BIT_OFF_RUN = 11;
  localparam int BIT_OFF_IDLE = 10;
  localparam int BIT_LOCK_HI = 9;
  localparam int BIT_LOCK_LO = 8;
  localparam int BIT_DEADBAND_HI = 7;
  localparam int BIT_DIR = 8;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
  localparam logic [7:0] SKIP_RESET = 8'h00;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] CH_RESET = 8'h00;
  localparam logic [1:0] LOCK_OFF = 2'h0;
  localparam logic [1:0] LOCK_LEVEL2 = 2'h2;
  localparam int POL_DELAY_CYCLES = 1;

  // Count direction of the time base
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

endpackage

// >>> core/compare_channel.sv
// One capture/compare channel: preload, active compare, capture latch.
// Assumes count and strobes come from the time base on the same clock.
module compare_channel
  import timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [15:0] wdata,
  input wire logic update,
  input wire logic preload_en,
  input wire logic input_mode,
  input wire logic capture_en,
  input wire logic capture_event,
  input wire logic [15:0] count,
  output logic [15:0] readback,
  output logic ref_r
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] preload_r;
  logic [15:0] active_r;
  logic [15:0] capture_r;
  wire take_capture = input_mode && capture_en && capture_event;

  // Preload written by software
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preload_r <= COUNTER_RESET;
    end else if (wr) begin
      preload_r <= wdata;
    end
  end

  // Active compare: direct or at update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_r <= COUNTER_RESET;
    end else if (!input_mode && wr && !preload_en) begin
      active_r <= wdata;
    end else if (!input_mode && update && preload_en) begin
      active_r <= preload_r;
    end
  end

  // Counter latched on a capture event
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capture_r <= COUNTER_RESET;
    end else if (take_capture) begin
      capture_r <= count;
    end
  end

  // Compare result, high while count is below the compare value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_r <= 1'b0;
    end else begin
      ref_r <= !input_mode && (count < active_r);
    end
  end

  // Input channels read the capture latch
  assign readback = input_mode ? capture_r : preload_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  cap_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
    take_capture |=> (readback == $past(count)) || !input_mode)
    else $error("capture value not latched");

  cmp_direct_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && !preload_en && !input_mode) |=> active_r == $past(wdata))
    else $error("direct compare load missed");

  cmp_ref_a: assert property (@(posedge sys_clk) disable iff (rst)
    !input_mode && (count < active_r) |=> ref_r)
    else $error("compare result wrong");

endmodule

// >>> core/timer_core.sv
// Timer time base, four compare channels and the fault output gate.
// Assumes synchronous inputs, one clock, and a master that never overlaps strobes.
//
// Notes on behaviour
// - Count tick fires once per active divider plus one input clocks.
// - Written divider moves into the active divider at every update event.
// - Period reload is a preload for the active reload; resets to FFFF.
// - Counter holds still while the active reload is zero.
// - Skip downcounter issues update at zero and reloads from the skip count.
// - New skip count takes effect only at the next skip reload or soft trigger.
// - Skip plus one counts periods, or half periods in center mode.
// - Compare value goes active at once without preload, else at update.
// - Each output channel compares its active value with the counter.
// - An input channel reads back the counter latched at its capture.
// - Active fault clears the main output gate without a clock edge.
// - Gate set by software or by auto-arm; acts on output channels only.
// - Gate clear idles outputs; gate set passes enabled outputs only.
// - With auto-arm, an update sets the gate if no fault is active.
// - Auto-arm and fault polarity are frozen at protection level one up.
// - Fault input is active low at polarity zero, high at one.
// - A new fault polarity acts one clock after the write.
// - Protection level is written once; any fault register write freezes it.
// - Fault input and clock failure are ignored unless fault enable is set.
module timer_core
  import timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic fault_input,
  input wire logic clock_monitor,
  input wire logic [3:0] capture_event,
  output logic [3:0] compare_output,
  output logic [3:0] inverted_compare_output,
  output logic main_output_gate
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire wr_ctrl = wr_en && (addr == OFS_CTRL);
  wire wr_trig = wr_en && (addr == OFS_TRIG);
  wire wr_chcfg = wr_en && (addr == OFS_CHCFG);
  wire wr_chen = wr_en && (addr == OFS_CHEN);
  wire wr_cnt = wr_en && (addr == OFS_COUNTER);
  wire wr_psc = wr_en && (addr == OFS_DIVIDER);
  wire wr_arr = wr_en && (addr == OFS_RELOAD);
  wire wr_rep = wr_en && (addr == OFS_SKIP);
  wire wr_fault = wr_en && (addr == OFS_FAULT);
  wire soft_update_trigger = wr_trig && wdata[BIT_SOFT_UPD];

  // ****************************************************************
  // State
  // ****************************************************************
  logic [2:0] ctrl_r;
  logic [7:0] chcfg_r;
  logic [7:0] chen_r;
  logic [15:0] counter_value_r;
  logic [15:0] counter_value_nxt;
  logic [15:0] clock_divider_r;
  logic [15:0] divider_active_r;
  logic [15:0] divider_count_r;
  logic [15:0] period_reload_r;
  logic [15:0] reload_active_r;
  logic [7:0] update_skip_count_r;
  logic [7:0] skip_downcounter_r;
  dir_t dir_r;
  dir_t dir_nxt;
  logic auto_arm_r;
  logic fault_polarity_r;
  logic polarity_eff_r;
  logic fault_enable_r;
  logic [1:0] lock_r;
  logic lock_frozen_r;
  logic [1:0] off_state_r;
  logic [7:0] deadband_r;
  logic gate_nxt;
  logic [31:0] rd_mux;
  logic [3:0] ref_w;
  logic [15:0] readback_w [4];
  logic [3:0] out_nxt;
  logic [3:0] inv_nxt;

  // ****************************************************************
  // Fault detection
  // ****************************************************************
  // Polarity select, then enable gate; clock failure counts as fault
  wire fault_level = polarity_eff_r ? fault_input : !fault_input;
  wire fault_active = fault_enable_r && (fault_level || clock_monitor);

  // ****************************************************************
  // Time base
  // ****************************************************************
  wire run_en = ctrl_r[BIT_RUN];
  wire center_mode = ctrl_r[BIT_CENTER];
  wire divider_wrap = (divider_count_r == divider_active_r);
  wire count_tick = run_en && divider_wrap && (reload_active_r != 16'h0000);
  wire at_top = (counter_value_r >= reload_active_r);
  wire at_bottom = (counter_value_r == 16'h0000);
  // Turnaround: wrap in edge mode, each end in center mode
  wire turnaround = center_mode ? ((dir_r == DIR_UP) ? at_top : at_bottom) : at_top;
  wire period_event = count_tick && turnaround;
  wire skip_reload_event = period_event && (skip_downcounter_r == 8'h00);
  wire update_event = soft_update_trigger || skip_reload_event;

  // Prescaler counter, cleared by the soft trigger
  always_ff @(posedge sys_clk) begin
    if (rst || soft_update_trigger) begin
      divider_count_r <= DIVIDER_RESET;
    end else if (run_en) begin
      divider_count_r <= divider_wrap ? DIVIDER_RESET : divider_count_r + 16'h0001;
    end
  end

  // Next counter value and direction
  always_comb begin
    counter_value_nxt = counter_value_r;
    dir_nxt = dir_r;
    if (soft_update_trigger) begin
      counter_value_nxt = COUNTER_RESET;
      dir_nxt = DIR_UP;
    end else if (wr_cnt) begin
      counter_value_nxt = wdata[15:0];
    end else if (count_tick) begin
      if (!center_mode) begin
        counter_value_nxt = at_top ? COUNTER_RESET : counter_value_r + 16'h0001;
      end else if (dir_r == DIR_UP) begin
        counter_value_nxt = at_top ? counter_value_r - 16'h0001 : counter_value_r + 16'h0001;
        dir_nxt = at_top ? DIR_DOWN : DIR_UP;
      end else begin
        counter_value_nxt = at_bottom ? counter_value_r + 16'h0001 : counter_value_r - 16'h0001;
        dir_nxt = at_bottom ? DIR_UP : DIR_DOWN;
      end
    end
  end

  // Counter and direction registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter_value_r <= COUNTER_RESET;
      dir_r <= DIR_UP;
    end else begin
      counter_value_r <= counter_value_nxt;
      dir_r <= dir_nxt;
    end
  end

  // Skip downcounter, reloaded only at its own reload or soft trigger
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skip_downcounter_r <= SKIP_RESET;
    end else if (soft_update_trigger || skip_reload_event) begin
      skip_downcounter_r <= update_skip_count_r;
    end else if (period_event) begin
      skip_downcounter_r <= skip_downcounter_r - 8'h01;
    end
  end

  // Active divider and active reload
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      divider_active_r <= DIVIDER_RESET;
      reload_active_r <= RELOAD_RESET;
    end else begin
      if (update_event) begin
        divider_active_r <= clock_divider_r;
      end
      if (!ctrl_r[BIT_RELOAD_PRE] || update_event) begin
        reload_active_r <= period_reload_r;
      end
    end
  end

  // ****************************************************************
  // Plain software registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
      chcfg_r <= CH_RESET;
      chen_r <= CH_RESET;
      clock_divider_r <= DIVIDER_RESET;
      period_reload_r <= RELOAD_RESET;
      update_skip_count_r <= SKIP_RESET;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata[2:0];
      if (wr_chcfg) chcfg_r <= wdata[7:0];
      if (wr_chen) chen_r <= wdata[7:0];
      if (wr_psc) clock_divider_r <= wdata[15:0];
      if (wr_arr) period_reload_r <= wdata[15:0];
      if (wr_rep) update_skip_count_r <= wdata[7:0];
    end
  end

  // ****************************************************************
  // Fault control register
  // ****************************************************************
  // Protected fields; protection level itself is write-once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      auto_arm_r <= 1'b0;
      fault_polarity_r <= 1'b0;
      fault_enable_r <= 1'b0;
      deadband_r <= 8'h00;
      off_state_r <= 2'h0;
      lock_r <= LOCK_OFF;
      lock_frozen_r <= 1'b0;
    end else if (wr_fault) begin
      lock_frozen_r <= 1'b1;
      if (!lock_frozen_r) lock_r <= wdata[BIT_LOCK_HI:BIT_LOCK_LO];
      if (lock_r == LOCK_OFF) begin
        auto_arm_r <= wdata[BIT_ARM];
        fault_polarity_r <= wdata[BIT_POL];
        fault_enable_r <= wdata[BIT_FEN];
        deadband_r <= wdata[BIT_DEADBAND_HI:0];
      end
      if (lock_r < LOCK_LEVEL2) off_state_r <= wdata[BIT_OFF_RUN:BIT_OFF_IDLE];
    end
  end

  // Polarity acts one clock after it is written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      polarity_eff_r <= 1'b0;
    end else begin
      polarity_eff_r <= fault_polarity_r;
    end
  end

  // ****************************************************************
  // Main output gate
  // ****************************************************************
  // Auto-arm set wins over a software clear in the same cycle
  assign gate_nxt = (wr_fault ? wdata[BIT_GATE] : main_output_gate)
    || (update_event && auto_arm_r);

  // Cleared at once by an active fault
  always_ff @(posedge sys_clk or posedge fault_active) begin
    if (fault_active) begin
      main_output_gate <= 1'b0;
    end else if (rst) begin
      main_output_gate <= 1'b0;
    end else begin
      main_output_gate <= gate_nxt;
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      compare_channel u_ch (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr(wr_en && (addr == OFS_CCR[gi])),
        .wdata(wdata[15:0]),
        .update(update_event),
        .preload_en(chcfg_r[2*gi+1]),
        .input_mode(chcfg_r[2*gi]),
        .capture_en(chen_r[2*gi]),
        .capture_event(capture_event[gi]),
        .count(counter_value_r),
        .readback(readback_w[gi]),
        .ref_r(ref_w[gi])
      );
      // Output only on output channels with gate and own enable
      assign out_nxt[gi] = main_output_gate && !chcfg_r[2*gi] && chen_r[2*gi]
        && ref_w[gi];
      assign inv_nxt[gi] = main_output_gate && !chcfg_r[2*gi] && chen_r[2*gi+1]
        && !ref_w[gi];
    end
  endgenerate

  // Registered pin outputs, idled at once by a fault
  always_ff @(posedge sys_clk or posedge fault_active) begin
    if (fault_active) begin
      compare_output <= 4'h0;
      inverted_compare_output <= 4'h0;
    end else if (rst) begin
      compare_output <= 4'h0;
      inverted_compare_output <= 4'h0;
    end else begin
      compare_output <= out_nxt;
      inverted_compare_output <= inv_nxt;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read mux, upper bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr)
      OFS_CTRL: rd_mux[2:0] = ctrl_r;
      OFS_CHCFG: rd_mux[7:0] = chcfg_r;
      OFS_CHEN: rd_mux[7:0] = chen_r;
      OFS_STAT: rd_mux[BIT_DIR:0] = {dir_r, skip_downcounter_r};
      OFS_COUNTER: rd_mux[15:0] = counter_value_r;
      OFS_DIVIDER: rd_mux[15:0] = clock_divider_r;
      OFS_RELOAD: rd_mux[15:0] = period_reload_r;
      OFS_SKIP: rd_mux[7:0] = update_skip_count_r;
      OFS_CCR[0]: rd_mux[15:0] = readback_w[0];
      OFS_CCR[1]: rd_mux[15:0] = readback_w[1];
      OFS_CCR[2]: rd_mux[15:0] = readback_w[2];
      OFS_CCR[3]: rd_mux[15:0] = readback_w[3];
      OFS_FAULT: rd_mux[15:0] = {main_output_gate, auto_arm_r, fault_polarity_r,
        fault_enable_r, off_state_r, lock_r, deadband_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stand for one cycle only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  tick_rate_a: assert property (@(posedge sys_clk) disable iff (rst)
    count_tick |-> divider_count_r == divider_active_r && $past(divider_count_r)
      != divider_active_r || divider_active_r == 16'h0000 || $past(soft_update_trigger)
      || $past(update_event))
    else $error("tick off prescaler period");

  divider_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    update_event |=> divider_active_r == $past(clock_divider_r))
    else $error("divider not loaded at update");

  zero_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (reload_active_r == 16'h0000 && !wr_cnt && !soft_update_trigger)
      |=> $stable(counter_value_r))
    else $error("counter moved with zero reload");

  skip_reload_a: assert property (@(posedge sys_clk) disable iff (rst)
    (period_event && skip_downcounter_r == 8'h00 && !soft_update_trigger)
      |-> update_event ##1 skip_downcounter_r == $past(update_skip_count_r))
    else $error("skip reload missed");

  skip_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_rep && !period_event && !soft_update_trigger) |=> $stable(skip_downcounter_r))
    else $error("skip count applied early");

  gate_fault_a: assert property (@(posedge sys_clk) disable iff (rst)
    fault_active |-> !main_output_gate && compare_output == 4'h0)
    else $error("gate open during fault");

  idle_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(main_output_gate) |-> compare_output == 4'h0 && inverted_compare_output == 4'h0)
    else $error("output driven with gate clear");

  auto_arm_a: assert property (@(posedge sys_clk) disable iff (rst)
    (update_event && auto_arm_r && !fault_active) ##1 !fault_active |-> main_output_gate)
    else $error("auto-arm did not set gate");

  lock_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_fault && lock_r != LOCK_OFF) |=> $stable(auto_arm_r) && $stable(fault_polarity_r))
    else $error("protected bit changed");

  pol_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(fault_polarity_r) |-> polarity_eff_r != fault_polarity_r
      ##1 polarity_eff_r == fault_polarity_r)
    else $error("polarity delay wrong");

  lock_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    lock_frozen_r |=> $stable(lock_r))
    else $error("protection level rewritten");

  fault_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !fault_enable_r |-> !fault_active)
    else $error("fault acted while disabled");

  skip_update_c: cover property (@(posedge sys_clk) disable iff (rst)
    skip_reload_event && update_skip_count_r != 8'h00);
  fault_clear_c: cover property (@(posedge sys_clk) disable iff (rst)
    $past(main_output_gate) && fault_active);
  auto_arm_c: cover property (@(posedge sys_clk) disable iff (rst)
    !main_output_gate ##1 main_output_gate && !$past(wr_fault));
  center_turn_c: cover property (@(posedge sys_clk) disable iff (rst)
    center_mode && period_event && dir_r == DIR_DOWN);

endmodule

// >>> tb/fault_source.sv
// Fault source model in front of the timer fault input.
// Assumes the bench sets the wanted fault state and the polarity in use.
module fault_source (
  input wire logic fault_on,
  input wire logic pol,
  output logic fault_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Fault level
  // ****
  assign fault_input = pol ? fault_on : !fault_on;
endmodule

// >>> tb/timer_timebase_compare_break_tb_top.sv
// Bench for the timer: registers, time base, capture, compares, fault gate.
// Assumes timer_pkg, timer_core and fault_source are compiled first.
module timer_timebase_compare_break_tb_top
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Clock, stimulus and parts
  // ****
  logic sys_clk = 0, rst = 1, wr_en = 0, rd_en = 0, fault_on = 0, pol = 0, gate, fin;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, a, seed = 32'h0000F819;
  logic [3:0] cap = 4'h0, co, ci;
  int err_count = 0, total_checks = 0, h, hn, c;
  always #25 sys_clk = ~sys_clk;
  fault_source PART (.fault_on(fault_on), .pol(pol), .fault_input(fin));
  timer_core DUT (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .fault_input(fin), .clock_monitor(1'b0),
    .capture_event(cap), .compare_output(co), .inverted_compare_output(ci),
    .main_output_gate(gate));
  // ****
  // Expectations and bus tasks
  // ****
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Counter ticks expected in a 24-cycle window
  function automatic int ticks(int p);
    return 24 / (p + 1);
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= ad;
    wdata <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= ad;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input logic [7:0] ad, input logic [31:0] exp);
    rd(ad, d);
    chk(d, exp);
  endtask
  // Counter advance between two reads 24 cycles apart
  task automatic rate(output logic [31:0] v);
    rd(OFS_COUNTER, a);
    repeat (22) @(posedge sys_clk);
    rd(OFS_COUNTER, v);
    v = (v - a) & 32'h0000FFFF;
  endtask
  // High cycles of channel 0 outputs over four periods
  task automatic outs();
    h = 0;
    hn = 0;
    repeat (2) @(posedge sys_clk);
    repeat (40) begin
      @(posedge sys_clk);
      #1 h += (co[0] === 1'b1);
      hn += (ci[0] === 1'b1);
    end
  endtask
  task automatic reset();
    rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    #(4000 * 50);
    err_count++;
    summarize();
  end
  initial begin
    reset();
    for (int i = 0; i < 10; i++) begin
      chkr(8'h24 + 8'(4 * i), i == 2 ? 32'h0000FFFF : 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      c = xs() & 32'h0000FFFF; // Upper half kept zero
      wr(8'h24 + 8'(4 * i), c);
      chkr(8'h24 + 8'(4 * i), i == 3 ? c & 255 : c);
    end
    $display("regs end");
    wr(OFS_RELOAD, 32'h0000FFFF);
    wr(OFS_CTRL, 32'h1);
    for (int p = 3; p >= 0; p--) begin
      wr(OFS_DIVIDER, p);
      wr(OFS_TRIG, 32'h1);
      rate(d);
      chk(d, ticks(p));
    end
    wr(OFS_DIVIDER, 32'h3);
    rate(d);
    chk(d, ticks(0));
    wr(OFS_RELOAD, 32'h0);
    rate(d);
    chk(d, 32'h0);
    wr(OFS_RELOAD, 32'h0000FFFF);
    wr(OFS_SKIP, 32'h3);
    wr(OFS_TRIG, 32'h1);
    chkr(OFS_STAT, 32'h3);
    wr(OFS_SKIP, 32'hFF);
    chkr(OFS_STAT, 32'h3);
    wr(OFS_CTRL, 32'h0);
    $display("base end");
    c = xs() & 32'h0000FFFF;
    wr(OFS_COUNTER, c);
    wr(OFS_CHCFG, 32'h4);
    wr(OFS_CHEN, 32'h4);
    @(posedge sys_clk) cap <= 4'h2;
    @(posedge sys_clk) cap <= 4'h0;
    chkr(OFS_CCR[1], c);
    chkr(OFS_COUNTER, c);
    $display("capture end");
    wr(OFS_FAULT, 32'h00008000);
    chkr(OFS_FAULT, 32'h00008000);
    fault_on <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(gate, 1'b1);
    fault_on <= 1'b0;
    wr(OFS_FAULT, 32'h0000A000);
    pol <= 1'b1;
    wr(OFS_FAULT, 32'h0000F000);
    chkr(OFS_FAULT, 32'h0000F000);
    c = 1 + xs() % 9;
    wr(OFS_RELOAD, 32'h9);
    wr(OFS_DIVIDER, 32'h0);
    wr(OFS_CHCFG, 32'h0);
    wr(OFS_CCR[0], c);
    wr(OFS_CHEN, 32'h3);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_TRIG, 32'h1);
    outs();
    chk(h, 4 * c);
    chk(hn, 40 - 4 * c);
    wr(OFS_CHCFG, 32'h2);
    wr(OFS_CCR[0], 10 - c);
    outs();
    chk(h, 4 * c);
    wr(OFS_TRIG, 32'h1);
    outs();
    chk(h, 40 - 4 * c);
    // Center mode: 11 ticks from zero turn at 9, down at 7, one event taken
    wr(OFS_CTRL, 32'h5);
    wr(OFS_TRIG, 32'h1);
    repeat (10) @(posedge sys_clk);
    chkr(OFS_STAT, 32'h000001FE);
    $display("compare end");
    @(posedge sys_clk) fault_on <= 1'b1;
    #1 chk({gate, co[0], ci[0]}, 3'h0);
    wr(OFS_FAULT, 32'h0000F000);
    #1 chk(gate, 1'b0);
    fault_on <= 1'b0;
    wr(OFS_TRIG, 32'h1);
    repeat (3) @(posedge sys_clk);
    #1 chk(gate, 1'b1);
    reset();
    wr(OFS_FAULT, 32'h00000100);
    wr(OFS_FAULT, 32'h00006000);
    chkr(OFS_FAULT, 32'h00000100);
    $display("fault end");
    summarize();
  end
endmodule
